// ==== rtl/ipc_defs.svh ====
// Offsets, field positions, reset values and timing counts of the priority controller
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH

// Sizes
`define IPC_NUM_SRC       8
`define IPC_NUM_TRAP      8
`define IPC_STACK_DEPTH   8
`define IPC_TMASK_W       14

// Priority codes
`define IPC_PRIO_RST      3'h4
`define IPC_PRIO_OFF      3'h0
`define IPC_IPL_ALL       3'h7
`define IPC_TMASK_TOP_LVL 3'h6
`define IPC_TRAP_BASE_LVL 4'h8

// Vector numbering
`define IPC_VEC_BIAS      8'h08
`define IPC_USER_VEC_BASE 8'h50

// Register byte offsets
`define IPC_OFF_CAN2EV    8'h00
`define IPC_OFF_DMA5      8'h04
`define IPC_OFF_SERERR    8'h08
`define IPC_OFF_CANTX     8'h0c
`define IPC_OFF_STATUS    8'h10
`define IPC_OFF_CTRL1     8'h14
`define IPC_OFF_STATLO    8'h18
`define IPC_OFF_TMASK     8'h1c

// Field positions (low bit of each field; priority and level fields are 3 bits, nesting 1, new level 4, vector index 7)
`define IPC_POS_CAN2EV    0
`define IPC_POS_DMA5      4
`define IPC_POS_SER2      8
`define IPC_POS_SER1      4
`define IPC_POS_C2TX      12
`define IPC_POS_C1TX      8
`define IPC_POS_DMA7      4
`define IPC_POS_DMA6      0
`define IPC_POS_NEST      15
`define IPC_POS_IPL       1
`define IPC_POS_NEWLVL    8
`define IPC_POS_VECIDX    0

// Timed disable: clocks per instruction cycle
`define IPC_TMASK_TICK_CYC 2

`endif

// ==== rtl/ipc_pkg.sv ====
// Types shared by the priority controller modules
package ipc_pkg;
  typedef logic [2:0] ipc_prio_t;
  typedef logic [3:0] ipc_level_t;
  typedef logic [7:0] ipc_vec_t;
endpackage

// ==== rtl/ipc_arbiter.sv ====
// Highest-priority selection among enabled pending user sources
`include "ipc_defs.svh"
module ipc_arbiter
  import ipc_pkg::*;
#(
  parameter int N = `IPC_NUM_SRC
) (
  input  wire logic [N*3-1:0] prio_i,
  input  wire logic [N-1:0]   flag_i,
  input  wire logic [N-1:0]   en_i,
  input  wire ipc_level_t     cpu_level_i,
  input  wire logic           tmask_i,
  input  wire logic           nest_block_i,
  output logic                hit_o,
  output logic [2:0]          idx_o,
  output ipc_prio_t           level_o
);
  logic [N-1:0] elig;

  // Per-source gating by code, level, timed disable and nesting
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_elig
      wire ipc_prio_t p = prio_i[g*3 +: 3];
      assign elig[g] = flag_i[g] && en_i[g]
                     && (p != `IPC_PRIO_OFF)
                     && ({1'b0, p} > cpu_level_i)
                     && !(tmask_i && (p <= `IPC_TMASK_TOP_LVL))
                     && !nest_block_i;
    end
  endgenerate

  // Strictly greater replaces, so ties keep the lower vector
  always_comb begin
    hit_o   = 1'b0;
    idx_o   = 3'h0;
    level_o = `IPC_PRIO_OFF;
    for (int i = 0; i < N; i++) begin
      if (elig[i] && (!hit_o || prio_i[i*3 +: 3] > level_o)) begin
        hit_o   = 1'b1;
        idx_o   = 3'(i);
        level_o = prio_i[i*3 +: 3];
      end
    end
  end
endmodule

// ==== rtl/ipc_timed_interrupt_disable_timer.sv ====
// Timed interrupt-disable counter paced by an instruction-cycle enable
`include "ipc_defs.svh"
module ipc_tmask_timer #(
  parameter int W    = `IPC_TMASK_W,
  parameter int TICK = `IPC_TMASK_TICK_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              active_o,
  output logic [W-1:0]      count_o
);
  logic [7:0] div_reg;
  logic       tick;

  // Instruction-cycle enable pulse
  assign tick = (div_reg == 8'(TICK - 1));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
    end else if (tick || load_i) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Load restarts the window; a tick counts it down
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o  <= '0;
      active_o <= 1'b0;
    end else if (load_i) begin
      count_o  <= value_i;
      active_o <= (value_i != '0);
    end else if (tick && count_o != '0) begin
      count_o  <= count_o - 1'b1;
      active_o <= (count_o != {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// ==== rtl/ipc_top.sv ====
// Interrupt priority control: priority fields, masking, nesting and vector status
//
// Contract
// - Each source has a 3-bit priority, 111 is level 7, 001 level 1.
// - Priority code 000 disables the source; it never interrupts.
// - Reset loads level 4 into every user priority field.
// - Unimplemented bits ignore writes and read as zero.
// - Read-only bits 11:8 report the new processor level, reset zero.
// - Read-only bits 6:0 report pending vector minus eight.
// - Nesting disable bit 15 stops user preemption of a running handler.
// - A flag still set at handler return requests again at once.
// - Return restores saved status byte and previous processor level.
// - Processor level 7 masks every user source of level 7 or below.
// - Traps, levels 8 to 15, are never masked.
// - Timed disable masks levels 1 to 6; level 7 still interrupts.
`include "ipc_defs.svh"
module ipc_top
  import ipc_pkg::*;
#(
  parameter int NSRC  = `IPC_NUM_SRC,
  parameter int DEPTH = `IPC_STACK_DEPTH
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [7:0]  SRC_FLAG_I,
  input  wire logic [7:0]  SRC_EN_I,
  input  wire logic [7:0]  TRAP_EVENT_I,
  input  wire logic        CPU_ACK_I,
  input  wire logic        CPU_RETURN_I,
  output logic             IRQ_REQ_O,
  output ipc_level_t       IRQ_LEVEL_O,
  output ipc_vec_t         IRQ_VECTOR_O,
  output ipc_level_t       CPU_LEVEL_O,
  output logic             TMASK_ACTIVE_O
);
  localparam int DW = $clog2(DEPTH + 1);

  // Source order: can2 event, dma5, serial2 err, serial1 err, can2 tx, can1 tx, dma7, dma6
  localparam logic [7:0] SRC_OFF [8] = '{`IPC_OFF_CAN2EV, `IPC_OFF_DMA5, `IPC_OFF_SERERR,
    `IPC_OFF_SERERR, `IPC_OFF_CANTX, `IPC_OFF_CANTX, `IPC_OFF_CANTX, `IPC_OFF_CANTX};
  localparam int SRC_POS [8] = '{`IPC_POS_CAN2EV, `IPC_POS_DMA5, `IPC_POS_SER2,
    `IPC_POS_SER1, `IPC_POS_C2TX, `IPC_POS_C1TX, `IPC_POS_DMA7, `IPC_POS_DMA6};

  ipc_prio_t      prio_reg [NSRC];
  logic [NSRC*3-1:0] prio_flat;
  logic           nesting_disable_reg;
  logic [7:0]     trap_flag_reg;
  logic [7:0]     status_low_byte_reg;
  ipc_level_t     cpu_level_reg;
  logic [3:0]     new_level_reg;
  logic [6:0]     vec_index_reg;
  logic [7:0]     stk_stat [DEPTH];
  ipc_level_t     stk_lvl [DEPTH];
  logic [DW-1:0]  depth_reg;
  logic           wr_en;
  logic           rd_en;
  logic [31:0]    rd_mux;
  logic           rd_hit;
  logic           usr_hit;
  logic [2:0]     usr_idx;
  ipc_prio_t      usr_level;
  logic           trap_hit;
  logic [2:0]     trap_idx;
  logic           sel_hit;
  ipc_level_t     sel_level;
  ipc_vec_t       sel_vec;
  logic           tmask_load;
  logic           tmask_active;
  logic [`IPC_TMASK_W-1:0] tmask_count;
  logic           nest_block;
  logic           do_push;
  logic           do_pop;

  // APB: one wait cycle so that the answer comes from flops
  // Writes land at the edge where the master samples pready high
  assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign rd_en = PSEL_I && PENABLE_I && !PREADY_O;
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (rd_en) begin
      PREADY_O  <= 1'b1;
      PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_mux;
      PSLVERR_O <= !rd_hit;
    end else begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end
  end

  // Read mux; every bit not named below stays zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    for (int i = 0; i < NSRC; i++) begin
      if (PADDR_I == SRC_OFF[i]) begin
        rd_mux[SRC_POS[i] +: 3] = prio_reg[i];
      end
    end
    case (PADDR_I)
      `IPC_OFF_CAN2EV, `IPC_OFF_DMA5, `IPC_OFF_SERERR, `IPC_OFF_CANTX: ;
      `IPC_OFF_STATUS: begin
        rd_mux[`IPC_POS_NEWLVL +: 4] = new_level_reg;
        rd_mux[`IPC_POS_VECIDX +: 7] = vec_index_reg;
      end
      `IPC_OFF_CTRL1: begin
        rd_mux[`IPC_POS_NEST] = nesting_disable_reg;
        rd_mux[7:0]           = trap_flag_reg;
      end
      `IPC_OFF_STATLO: rd_mux[7:0] = status_low_byte_reg;
      `IPC_OFF_TMASK:  rd_mux[`IPC_TMASK_W-1:0] = tmask_count;
      default:       rd_hit = 1'b0;
    endcase
  end

  // Priority fields; only the 3-bit fields take write data
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_prio
      always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
          prio_reg[g] <= `IPC_PRIO_RST;
        end else if (wr_en && PADDR_I == SRC_OFF[g]) begin
          prio_reg[g] <= PWDATA_I[SRC_POS[g] +: 3];
        end
      end
      assign prio_flat[g*3 +: 3] = prio_reg[g];
    end
  endgenerate

  // Nesting disable control bit
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      nesting_disable_reg <= 1'b0;
    end else if (wr_en && PADDR_I == `IPC_OFF_CTRL1) begin
      nesting_disable_reg <= PWDATA_I[`IPC_POS_NEST];
    end
  end

  // Trap flags: write one to clear, a new trap event wins over the clear
  // A trap raised in the very cycle of the clear survives, so none is lost
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      trap_flag_reg <= 8'h00;
    end else if (wr_en && PADDR_I == `IPC_OFF_CTRL1) begin
      trap_flag_reg <= (trap_flag_reg & ~PWDATA_I[7:0]) | TRAP_EVENT_I;
    end else begin
      trap_flag_reg <= trap_flag_reg | TRAP_EVENT_I;
    end
  end

  // Highest pending trap above the running level; never masked
  always_comb begin
    trap_hit = 1'b0;
    trap_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (trap_flag_reg[i] && (`IPC_TRAP_BASE_LVL + 4'(i)) > cpu_level_reg) begin
        trap_hit = 1'b1;
        trap_idx = 3'(i);
      end
    end
  end

  // Nesting is blocked only for user sources, traps still preempt
  assign nest_block = nesting_disable_reg && (depth_reg != '0);

  // Nesting and the timed mask gate users ahead of the level compare
  ipc_arbiter #(
    .N (NSRC)
  ) u_arb (
    .prio_i       (prio_flat),
    .flag_i       (SRC_FLAG_I),
    .en_i         (SRC_EN_I),
    .cpu_level_i  (cpu_level_reg),
    .tmask_i      (tmask_active),
    .nest_block_i (nest_block),
    .hit_o        (usr_hit),
    .idx_o        (usr_idx),
    .level_o      (usr_level)
  );

  // Trap outranks any user source
  assign sel_hit   = trap_hit || usr_hit;
  assign sel_level = trap_hit ? (`IPC_TRAP_BASE_LVL + {1'b0, trap_idx}) : {1'b0, usr_level};
  assign sel_vec   = trap_hit ? {5'h00, trap_idx} : (`IPC_USER_VEC_BASE + {5'h00, usr_idx});

  // Request to the core; flags are left for software, so a held flag refires
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_REQ_O    <= 1'b0;
      IRQ_LEVEL_O  <= 4'h0;
      IRQ_VECTOR_O <= 8'h00;
    end else begin
      IRQ_REQ_O    <= sel_hit && !do_push;
      IRQ_LEVEL_O  <= sel_hit ? sel_level : 4'h0;
      IRQ_VECTOR_O <= sel_hit ? sel_vec : 8'h00;
    end
  end

  // Status fields: new level and biased vector of the pending request
  // Trap vectors sit below the bias, so their index wraps; read traps from the control word
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      new_level_reg <= 4'h0;
      vec_index_reg <= 7'h00;
    end else begin
      new_level_reg <= sel_hit ? sel_level : 4'h0;
      vec_index_reg <= sel_hit ? 7'(sel_vec - `IPC_VEC_BIAS) : 7'h00;
    end
  end

  // Entry stacks the status byte and level; return unstacks both
  assign do_pop  = CPU_RETURN_I && (depth_reg != '0);
  assign do_push = CPU_ACK_I && IRQ_REQ_O && !do_pop && (depth_reg != DW'(DEPTH));
  // Storage has no reset; depth gates every read, so stale entries never surface
  always_ff @(posedge MCLK_I) begin
    if (do_push) begin
      stk_stat[depth_reg[$clog2(DEPTH)-1:0]] <= status_low_byte_reg;
      stk_lvl[depth_reg[$clog2(DEPTH)-1:0]] <= cpu_level_reg;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      depth_reg <= '0;
    end else if (do_pop) begin
      depth_reg <= depth_reg - 1'b1;
    end else if (do_push) begin
      depth_reg <= depth_reg + 1'b1;
    end
  end

  // Running level and status byte; writing the byte sets the user level
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      status_low_byte_reg <= 8'h00;
      cpu_level_reg       <= 4'h0;
    end else if (do_pop) begin
      status_low_byte_reg <= stk_stat[3'(depth_reg - 1'b1)];
      cpu_level_reg       <= stk_lvl[3'(depth_reg - 1'b1)];
    end else if (do_push) begin
      cpu_level_reg <= IRQ_LEVEL_O;
      status_low_byte_reg[`IPC_POS_IPL +: 3] <= IRQ_LEVEL_O[3] ? `IPC_IPL_ALL : IRQ_LEVEL_O[2:0];
    end else if (wr_en && PADDR_I == `IPC_OFF_STATLO) begin
      status_low_byte_reg <= PWDATA_I[7:0];
      // Inside a trap only a return may lower the level
      if (!cpu_level_reg[3]) begin
        cpu_level_reg <= {1'b0, PWDATA_I[`IPC_POS_IPL +: 3]};
      end
    end
  end

  // Timed mask window; the written word is the count itself
  assign tmask_load = wr_en && PADDR_I == `IPC_OFF_TMASK;
  ipc_tmask_timer #(
    .W    (`IPC_TMASK_W),
    .TICK (`IPC_TMASK_TICK_CYC)
  ) u_tmask (
    .clk_i    (MCLK_I),
    .rst_i    (RST_I),
    .load_i   (tmask_load),
    .value_i  (PWDATA_I[`IPC_TMASK_W-1:0]),
    .active_o (tmask_active),
    .count_o  (tmask_count)
  );

  // Mirrors for the core
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      CPU_LEVEL_O    <= 4'h0;
      TMASK_ACTIVE_O <= 1'b0;
    end else begin
      CPU_LEVEL_O    <= cpu_level_reg;
      TMASK_ACTIVE_O <= tmask_active;
    end
  end

  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  // Reset values and register bus
  a_field_reset:   assert property ($past(RST_I) |-> prio_flat == {NSRC{`IPC_PRIO_RST}})
    else $error("priority fields not at level 4 after reset");
  a_status_reset:  assert property ($past(RST_I) |-> new_level_reg == 4'h0 && vec_index_reg == 7'h00)
    else $error("status fields not zero after reset");
  a_upper_zero:    assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_slverr_data:   assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_ready_pulse:   assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held for more than one cycle");

  // Selection, masking and status fields
  a_disabled_silent: assert property (usr_hit |-> prio_reg[usr_idx] != `IPC_PRIO_OFF)
    else $error("disabled source selected");
  a_level_follows: assert property (sel_hit && !trap_hit |=> new_level_reg == {1'b0, $past(usr_level)})
    else $error("new level field does not follow selection");
  a_vector_bias:   assert property (IRQ_REQ_O && IRQ_VECTOR_O >= 8'h08 |->
    vec_index_reg == 7'(IRQ_VECTOR_O - 8'h08))
    else $error("vector field not vector minus eight");
  a_nest_blocked:  assert property (nesting_disable_reg && depth_reg != '0 |-> !usr_hit)
    else $error("user source nested while disabled");
  a_flag_refire:   assert property (usr_hit && !do_push |=> IRQ_REQ_O)
    else $error("pending source not requested");
  a_ipl_masks:     assert property (cpu_level_reg == 4'h7 |-> !usr_hit)
    else $error("user source passed level 7 mask");
  a_tmask_mask:    assert property (tmask_active && usr_hit |-> usr_level == 3'h7)
    else $error("timed disable let a low level through");
  a_tie_lower:     assert property (usr_hit && usr_idx != 3'h0 && SRC_FLAG_I[0] && SRC_EN_I[0]
    && !tmask_active |-> prio_reg[0] < usr_level || prio_reg[0] <= cpu_level_reg[2:0] || cpu_level_reg[3])
    else $error("tie not broken toward lower vector");

  // Entry, return and traps
  a_entry_level:   assert property (do_push |=> cpu_level_reg == $past(IRQ_LEVEL_O))
    else $error("entry did not raise level to request");
  a_return_level:  assert property (do_pop |=> cpu_level_reg == $past(stk_lvl[3'(depth_reg - 1'b1)]))
    else $error("return did not restore previous level");
  a_trap_passes:   assert property (trap_flag_reg[7] && cpu_level_reg < 4'hf && !CPU_ACK_I |=>
    IRQ_REQ_O && IRQ_LEVEL_O == 4'hf)
    else $error("top trap masked");
  a_trap_vector:   assert property (IRQ_REQ_O && IRQ_LEVEL_O[3] |-> IRQ_VECTOR_O == 8'(IRQ_LEVEL_O - 4'h8))
    else $error("trap vector does not match level");

  c_user_taken:   cover property (IRQ_REQ_O && CPU_ACK_I && !IRQ_LEVEL_O[3]);
  c_trap_nested:  cover property (do_push && IRQ_LEVEL_O[3] && depth_reg != '0);
  c_tmask_level7: cover property (tmask_active && usr_hit && usr_level == 3'h7);
  c_refire:       cover property (do_pop ##2 IRQ_REQ_O);
  c_trap_top:     cover property (IRQ_REQ_O && IRQ_LEVEL_O == 4'hf);
endmodule

// ==== testbench/ipc_core_model.sv ====
// Behavioural processor core that accepts requests and returns from handlers
module ipc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_req_i,
  input  wire logic       ack_en_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       ret_req_i,
  output logic            ack_o,
  output logic            ret_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_reg;
  logic [1:0] hold_reg;

  // Accept after a chosen delay; holdoff keeps acks apart while the request drops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg <= 4'h0;
      hold_reg <= 2'h0;
      ack_o    <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (hold_reg != 2'h0) begin
        hold_reg <= hold_reg - 2'h1;
      end
      if (!irq_req_i || !ack_en_i) begin
        wait_reg <= 4'h0;
      end else if (wait_reg < delay_i) begin
        wait_reg <= wait_reg + 4'h1;
      end else if (hold_reg == 2'h0 && !ack_o) begin
        ack_o    <= 1'b1;
        hold_reg <= 2'h3;
        wait_reg <= 4'h0;
      end
    end
  end

  // Handler return, one pulse a cycle after the bench asks for it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ret_o <= 1'b0;
    end else begin
      ret_o <= ret_req_i;
    end
  end
endmodule

// ==== testbench/test_interrupt_priority_control.sv ====
// Self-checking bench for the interrupt priority controller
`include "ipc_defs.svh"
module test_interrupt_priority_control
  import ipc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  flag = 8'h00;
  logic [7:0]  en = 8'h00;
  logic [7:0]  trap_ev = 8'h00;
  logic        ack;
  logic        ret;
  logic        ack_en = 1'b0;
  logic [3:0]  ack_dly = 4'h2;
  logic        ret_req = 1'b0;
  logic        irq_req;
  ipc_level_t  irq_level;
  ipc_vec_t    irq_vector;
  ipc_level_t  cpu_level;
  logic        tmask_act;
  int          prio [8];
  int          err_count = 0;
  int          checks_done = 0;
  int          seed = 42865;
  logic [31:0] rd;
  logic        er;

  ipc_top u_dut (
    .MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SRC_FLAG_I(flag), .SRC_EN_I(en), .TRAP_EVENT_I(trap_ev), .CPU_ACK_I(ack), .CPU_RETURN_I(ret),
    .IRQ_REQ_O(irq_req), .IRQ_LEVEL_O(irq_level), .IRQ_VECTOR_O(irq_vector),
    .CPU_LEVEL_O(cpu_level), .TMASK_ACTIVE_O(tmask_act));

  ipc_core_model u_core (
    .clk_i(clk), .rst_i(rst), .irq_req_i(irq_req), .ack_en_i(ack_en),
    .delay_i(ack_dly), .ret_req_i(ret_req), .ack_o(ack), .ret_o(ret));

  // Free-running system clock
  always #5 clk = ~clk;

  task automatic test_done;
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB master: request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register image built from the bench's own copy of the priorities
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    logic [7:0] off [8];
    int         pos [8];
    logic [31:0] w;
    off = '{`IPC_OFF_CAN2EV, `IPC_OFF_DMA5, `IPC_OFF_SERERR, `IPC_OFF_SERERR,
            `IPC_OFF_CANTX, `IPC_OFF_CANTX, `IPC_OFF_CANTX, `IPC_OFF_CANTX};
    pos = '{`IPC_POS_CAN2EV, `IPC_POS_DMA5, `IPC_POS_SER2, `IPC_POS_SER1,
            `IPC_POS_C2TX, `IPC_POS_C1TX, `IPC_POS_DMA7, `IPC_POS_DMA6};
    w = 32'h0;
    for (int i = 0; i < 8; i++) begin
      if (off[i] == a) begin
        w = w | (32'(prio[i] & 7) << pos[i]);
      end
    end
    return w;
  endfunction

  task automatic set_all(input logic [31:0] raw, input logic use_raw);
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b1, 8'(a), use_raw ? raw : reg_word(8'(a)));
    end
  endtask

  task automatic chk_regs;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("prio_reg", reg_word(8'(a)), rd);
    end
  endtask

  // Reference arbiter: strict greater keeps ties with the lower index
  function automatic int pick(input int lvl, input bit tmask, input bit blk);
    int best;
    int bi;
    best = 0;
    bi = -1;
    for (int i = 0; i < 8; i++) begin
      if (flag[i] && en[i] && prio[i] > lvl && !blk && !(tmask && prio[i] < 7) && prio[i] > best) begin
        best = prio[i];
        bi = i;
      end
    end
    return bi;
  endfunction

  task automatic chk_irq(input int lvl, input bit tmask, input bit blk);
    int bi;
    // Model reads flags only after the bench's own updates have landed
    repeat (3) @(posedge clk);
    bi = pick(lvl, tmask, blk);
    chk("irq_req", 32'(bi >= 0), {31'h0, irq_req});
    if (bi >= 0) begin
      chk("irq_level", 32'(prio[bi]), {28'h0, irq_level});
      chk("irq_vector", `IPC_USER_VEC_BASE + bi, {24'h0, irq_vector});
    end
    apb(1'b0, `IPC_OFF_STATUS, 32'h0);
    chk("status", bi < 0 ? 32'h0 : (32'(prio[bi]) << 8) |
        ((`IPC_USER_VEC_BASE + bi - `IPC_VEC_BIAS) & 32'h7f), rd);
  endtask

  // Bounded watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    int n;
    foreach (prio[i]) prio[i] = 4;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk_regs();
    chk_irq(0, 0, 0);
    set_all(32'hffffffff, 1'b1);
    foreach (prio[i]) prio[i] = 7;
    chk_regs();
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    // Random priorities, flags and enables against the reference arbiter
    for (int k = 0; k < 16; k++) begin
      foreach (prio[i]) prio[i] = $random(seed) & 7;
      set_all(32'h0, 1'b0);
      flag <= 8'($random(seed));
      en   <= 8'($random(seed));
      chk_irq(0, 0, 0);
    end
    // One common level, then masking by the processor level and traps
    flag <= 8'h00;
    foreach (prio[i]) prio[i] = 7;
    set_all(32'h0, 1'b0);
    en   <= 8'h01;
    flag <= 8'h01;
    apb(1'b1, `IPC_OFF_STATLO, 32'h0e);
    repeat (3) @(posedge clk);
    chk("cpu_level", 32'h7, {28'h0, cpu_level});
    chk_irq(7, 0, 0);
    trap_ev <= 8'h88;
    @(posedge clk);
    trap_ev <= 8'h00;
    repeat (3) @(posedge clk);
    chk("trap_req", 32'h1, {31'h0, irq_req});
    chk("trap_level", 32'h8 + 7, {28'h0, irq_level});
    chk("trap_vector", 32'h7, {24'h0, irq_vector});
    apb(1'b0, `IPC_OFF_CTRL1, 32'h0);
    chk("trap_flag", 32'h0088, rd);
    apb(1'b1, `IPC_OFF_CTRL1, 32'h0088);
    chk_irq(7, 0, 0);
    apb(1'b1, `IPC_OFF_STATLO, 32'h00);
    chk_irq(0, 0, 0);
    // Timed disable lets level 7 through and holds back level 6
    prio[0] = 6;
    set_all(32'h0, 1'b0);
    en   <= 8'h03;
    flag <= 8'h03;
    apb(1'b1, `IPC_OFF_TMASK, 32'd20);
    repeat (2) @(posedge clk);
    chk("tmask_active", 32'h1, {31'h0, tmask_act});
    chk_irq(0, 1, 0);
    flag <= 8'h01;
    chk_irq(0, 1, 0);
    for (n = 0; n < 100 && tmask_act !== 1'b0; n++) @(posedge clk);
    chk("tmask_end", 32'h0, {31'h0, tmask_act});
    chk_irq(0, 0, 0);
    // Nesting disable, slow acceptance, return and re-request
    apb(1'b1, `IPC_OFF_CTRL1, 32'h8000);
    ack_en <= 1'b1;
    for (n = 0; n < 50 && cpu_level !== 4'h6; n++) @(posedge clk);
    ack_en <= 1'b0;
    chk("cpu_level", 32'h6, {28'h0, cpu_level});
    apb(1'b0, `IPC_OFF_STATLO, 32'h0);
    chk("status_low", 32'h0c, rd);
    prio[5] = 7;
    set_all(32'h0, 1'b0);
    en   <= 8'h21;
    flag <= 8'h21;
    chk_irq(6, 0, 1);
    apb(1'b1, `IPC_OFF_CTRL1, 32'h0);
    chk_irq(6, 0, 0);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cpu_level", 32'h0, {28'h0, cpu_level});
    apb(1'b0, `IPC_OFF_STATLO, 32'h0);
    chk("status_low", 32'h00, rd);
    chk_irq(0, 0, 0);
    test_done();
  end
endmodule
